// ### pin_sync.sv
/*
  Two-flop synchroniser for a vector of independent level inputs.
  Assumes each bit changes slowly relative to the sampling clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ### spi_host_model.sv
/*
  Host-side serial master: one word per chip-select frame.
  Assumes the slave samples every pin with its own clock.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input  wire logic clk,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic si,
  input  wire logic so
);
  // 200 ns period: each half spans four system cycles, well under 8 MHz
  localparam int HALF = 4;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  // n pulses, the first 16 carry w; r gathers the reply
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    pause(HALF);
    for (int i = 0; i < n; i++) begin
      si = (i < 16) ? w[15 - i] : ~si;
      pause(HALF);
      sclk = 1'b1;
      r = {r[14:0], so};
      pause(HALF);
      sclk = 1'b0;
    end
    pause(HALF);
    cs_n = 1'b1;
    si = ~si; // released line must not look like the last bit
    pause(8);
  endtask
endmodule
`default_nettype wire

// ### spi_register_access_slave.sv
/*
  Sixteen-bit serial register-access slave: frames commands from the host,
  holds configuration, control and system status registers, and replies
  to each command during the next frame.
  Assumes the host's serial clock is far slower than CLK_SYS (four or more
  system cycles per half period) and that chip select moves with SCLK low.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_register_access_slave (
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        SCLK,
  input  wire logic        SERIAL_IN,
  output logic             SERIAL_OUT,
  output logic             SERIAL_OUT_OE,
  input  wire logic        KEY_SWITCH_STATE,
  input  wire logic        POWER_ENABLE_STATE,
  input  wire logic        BATTERY_SWITCH_STATE,
  input  wire logic [2:0]  SENSOR_SUPPLY_FAULT,
  input  wire logic        OTHER_FAULT,
  output logic [95:0]      CFG_REGS,
  output logic [95:0]      CTRL_REGS,
  output logic [7:0]       SYS_STATUS,
  output logic             SELF_TEST_WRITE_UNLOCK
);

  logic [spi_regs_pkg::PIN_BITS-1:0] pins_raw;
  logic [spi_regs_pkg::PIN_BITS-1:0] pins_s;

  logic       csn_s;
  logic       sclk_s;
  logic       si_s;
  logic [2:0] state_s;
  logic [2:0] supply_fault_s;
  logic       other_fault_s;

  // every pin is asynchronous to CLK_SYS; chip select idles high
  assign pins_raw = {CHIP_SELECT_N, SCLK, SERIAL_IN, KEY_SWITCH_STATE,
                     POWER_ENABLE_STATE, BATTERY_SWITCH_STATE,
                     SENSOR_SUPPLY_FAULT, OTHER_FAULT};

  pin_sync #(
    .W       (spi_regs_pkg::PIN_BITS),
    .RST_VAL (spi_regs_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign csn_s          = pins_s[9];
  assign sclk_s         = pins_s[8];
  assign si_s           = pins_s[7];
  assign state_s        = pins_s[6:4];
  assign supply_fault_s = pins_s[3:1];
  assign other_fault_s  = pins_s[0];

  // edge detection on the synchronised copies
  logic csn_d_r;
  logic sclk_d_r;
  logic csn_d_nxt;
  logic sclk_d_nxt;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  always_comb begin
    csn_d_nxt  = csn_s;
    sclk_d_nxt = sclk_s;
    cs_fall    = csn_d_r & ~csn_s;
    cs_rise    = ~csn_d_r & csn_s;
    sclk_rise  = ~sclk_d_r & sclk_s & ~csn_s; // RULE_24
    sclk_fall  = sclk_d_r & ~sclk_s & ~csn_s; // RULE_24
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      csn_d_r  <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      csn_d_r  <= csn_d_nxt;
      sclk_d_r <= sclk_d_nxt;
    end
  end

  // shift path
  logic [15:0]                       rx_r;
  logic [15:0]                       tx_r;
  logic [spi_regs_pkg::CNT_BITS-1:0] cnt_r;
  logic                              so_r;
  logic                              so_oe_r;
  logic [15:0]                       rx_nxt;
  logic [15:0]                       tx_nxt;
  logic [spi_regs_pkg::CNT_BITS-1:0] cnt_nxt;
  logic                              so_nxt;
  logic                              so_oe_nxt;
  logic [15:0]                       resp_r;
  logic [15:0]                       resp_nxt;

  always_comb begin
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    cnt_nxt   = cnt_r;
    so_nxt    = so_r;
    so_oe_nxt = so_oe_r;
    if (cs_fall) begin
      tx_nxt    = resp_r;                 // RULE_08
      so_nxt    = resp_r[15];             // RULE_05
      so_oe_nxt = 1'b1;                   // RULE_03
      cnt_nxt   = '0;
      rx_nxt    = '0;
    end
    if (sclk_rise) begin
      rx_nxt = {rx_r[14:0], si_s};        // RULE_01
      // saturate one above a full word so long frames stay detectable
      if (cnt_r <= spi_regs_pkg::FRAME_PULSES) begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    if (sclk_fall) begin
      tx_nxt = {tx_r[14:0], 1'b0};        // RULE_05
      so_nxt = tx_r[14];                  // RULE_06
    end
    if (cs_rise) begin
      so_oe_nxt = 1'b0;                   // RULE_03
      so_nxt    = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rx_r    <= '0;
      tx_r    <= '0;
      cnt_r   <= '0;
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      rx_r    <= rx_nxt;
      tx_r    <= tx_nxt;
      cnt_r   <= cnt_nxt;
      so_r    <= so_nxt;
      so_oe_r <= so_oe_nxt;
    end
  end

  // register file
  logic [7:0] cfg_r   [spi_regs_pkg::CFG_COUNT];
  logic [7:0] cfg_nxt [spi_regs_pkg::CFG_COUNT];
  logic [7:0] ctrl_r   [spi_regs_pkg::CTRL_COUNT];
  logic [7:0] ctrl_nxt [spi_regs_pkg::CTRL_COUNT];
  logic [7:0] st_r;
  logic [7:0] st_nxt;

  function automatic logic [7:0] cfg_mask(input logic [3:0] idx);
    cfg_mask = spi_regs_pkg::CFG_MASKS[idx*8 +: 8];
  endfunction

  function automatic logic [7:0] cfg_reset(input logic [3:0] idx);
    cfg_reset = spi_regs_pkg::CFG_RESET_VALUES[idx*8 +: 8];
  endfunction

  // command decode, only meaningful on the release edge
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [7:0] data;
  logic       frame_ok;
  logic       cmd_valid;
  logic       exec;
  logic       err_event;
  logic       wr_cfg;
  logic       wr_ctrl;
  logic       wr_st;
  logic       cfg_addr_ok;
  logic       ctrl_addr_ok;
  logic       unlock;
  logic [15:0] resp_cmd;

  assign unlock = ctrl_r[spi_regs_pkg::CTRL_UNLOCK_ADDR][spi_regs_pkg::CTRL_UNLOCK_BIT];

  always_comb begin
    cmd          = rx_r[15:spi_regs_pkg::CMD_LSB];      // RULE_14
    addr         = rx_r[spi_regs_pkg::CMD_LSB-1:spi_regs_pkg::ADDR_LSB];
    data         = rx_r[spi_regs_pkg::DATA_BITS-1:0];
    frame_ok     = (cnt_r == spi_regs_pkg::FRAME_PULSES); // RULE_02 RULE_12
    cfg_addr_ok  = (addr < 4'(spi_regs_pkg::CFG_COUNT));
    ctrl_addr_ok = (addr < 4'(spi_regs_pkg::CTRL_COUNT));
    cmd_valid    = 1'b0;
    wr_cfg       = 1'b0;
    wr_ctrl      = 1'b0;
    wr_st        = 1'b0;
    resp_cmd     = rx_r;                  // writes echo the word sent
    case (cmd)                            // RULE_15
      spi_regs_pkg::CMD_ECHO: begin
        cmd_valid = 1'b1;
        resp_cmd  = {spi_regs_pkg::CMD_ECHO_RESP, rx_r[11:0]}; // RULE_11
      end
      spi_regs_pkg::CMD_RD_CFG: begin
        cmd_valid = cfg_addr_ok;
        resp_cmd  = {cmd, addr, cfg_addr_ok ? cfg_r[addr] : 8'h00}; // RULE_26
      end
      spi_regs_pkg::CMD_WR_CFG: begin
        cmd_valid = cfg_addr_ok;
        wr_cfg    = cfg_addr_ok;
      end
      spi_regs_pkg::CMD_RD_STATUS: begin
        cmd_valid = (addr == spi_regs_pkg::SYS_STATUS_ADDR);
        resp_cmd  = {cmd, addr, st_r};    // RULE_04 RULE_26
      end
      spi_regs_pkg::CMD_WR_STATUS: begin
        cmd_valid = (addr == spi_regs_pkg::SYS_STATUS_ADDR);
        wr_st     = cmd_valid;
      end
      spi_regs_pkg::CMD_RD_CTRL: begin
        cmd_valid = ctrl_addr_ok;
        resp_cmd  = {cmd, addr, ctrl_addr_ok ? ctrl_r[addr] : 8'h00}; // RULE_26
      end
      spi_regs_pkg::CMD_WR_CTRL: begin
        cmd_valid = ctrl_addr_ok;
        wr_ctrl   = ctrl_addr_ok;
      end
      default: begin
        cmd_valid = 1'b0;                 // RULE_13
      end
    endcase
    exec      = cs_rise & frame_ok & cmd_valid;          // RULE_17 RULE_20
    err_event = cs_rise & ~(frame_ok & cmd_valid);       // RULE_12 RULE_13
  end

  always_comb begin
    for (int i = 0; i < spi_regs_pkg::CFG_COUNT; i++) begin
      cfg_nxt[i] = cfg_r[i];
      if (exec && wr_cfg && addr == 4'(i)) begin
        cfg_nxt[i] = data & cfg_mask(4'(i));              // RULE_16 RULE_18
      end
    end
    for (int i = 0; i < spi_regs_pkg::CTRL_COUNT; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      if (exec && wr_ctrl && addr == 4'(i)) begin
        ctrl_nxt[i] = data & spi_regs_pkg::CTRL_MASK;     // RULE_16
      end
    end
  end

  // status: the write is applied first so a same-cycle fault set wins
  always_comb begin
    st_nxt = st_r;
    if (exec && wr_st) begin
      if (unlock) begin
        st_nxt = data & spi_regs_pkg::SYS_STATUS_MASK;    // RULE_10 RULE_18
      end else begin
        st_nxt = st_r & data;                             // RULE_09 RULE_25
      end
    end
    // self-test freezes recording so written patterns read back intact
    if (!unlock) begin                                    // RULE_10
      st_nxt[spi_regs_pkg::ST_SUPPLY_MSB:0] =
        st_nxt[spi_regs_pkg::ST_SUPPLY_MSB:0] | supply_fault_s; // RULE_22
      st_nxt[spi_regs_pkg::ST_SPI_ERROR] =
        st_nxt[spi_regs_pkg::ST_SPI_ERROR] | err_event;   // RULE_25 RULE_22
      st_nxt[spi_regs_pkg::ST_KEY_SWITCH:spi_regs_pkg::ST_BATTERY_SW] = state_s; // RULE_19
      st_nxt[spi_regs_pkg::ST_ANY_FAULT] =
        (|st_nxt[spi_regs_pkg::ST_SPI_ERROR:0]) | other_fault_s; // RULE_22
    end
  end

  // reply for the next frame
  always_comb begin
    resp_nxt = resp_r;
    if (exec) begin
      resp_nxt = resp_cmd;                                // RULE_08
    end else if (cs_rise) begin
      // a rejected frame answers with the system status, error bit shown
      resp_nxt = {spi_regs_pkg::CMD_RD_STATUS, spi_regs_pkg::SYS_STATUS_ADDR,
                  st_r | (8'h01 << spi_regs_pkg::ST_SPI_ERROR)};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      for (int i = 0; i < spi_regs_pkg::CFG_COUNT; i++) begin
        cfg_r[i] <= cfg_reset(4'(i));
      end
      for (int i = 0; i < spi_regs_pkg::CTRL_COUNT; i++) begin
        ctrl_r[i] <= spi_regs_pkg::CTRL_RESET;
      end
      st_r   <= spi_regs_pkg::SYS_STATUS_RESET;
      resp_r <= '0;
    end else begin
      cfg_r  <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      st_r   <= st_nxt;
      resp_r <= resp_nxt;
    end
  end

  // outputs, all taken straight from flops
  always_comb begin
    for (int i = 0; i < spi_regs_pkg::CFG_COUNT; i++) begin
      CFG_REGS[i*8 +: 8] = cfg_r[i];
    end
    for (int i = 0; i < spi_regs_pkg::CTRL_COUNT; i++) begin
      CTRL_REGS[i*8 +: 8] = ctrl_r[i];
    end
  end

  assign SERIAL_OUT             = so_r;
  assign SERIAL_OUT_OE          = so_oe_r;
  assign SYS_STATUS             = st_r;
  assign SELF_TEST_WRITE_UNLOCK = unlock;

endmodule
`default_nettype wire

// ### spi_regs_pkg.sv
/*
  Constants shared by the serial register-access slave: word layout, command
  codes, register addresses, implemented-bit masks and reset values.
  Assumes a single 16-bit command word per chip-select frame.
*/
// Behaviour
// RULE_01: sample serial input on rising serial clock
// RULE_02: command word is exactly sixteen bits
// RULE_03: output floats while deselected, drives after select
// RULE_04: status bits read one for fault
// RULE_05: both words shift most significant bit first
// RULE_06: output changes on falling serial clock edge
// RULE_07: master keeps serial clock at most 8 MHz
// RULE_08: reply shifts out during the following frame
// RULE_09: locked status write only clears bits
// RULE_10: unlocked status writable, fault recording suspended
// RULE_11: echo command returns word with code seven
// RULE_12: wrong pulse count discards frame, flags error
// RULE_13: bad command or address flags error
// RULE_14: code, address, data fields in word
// RULE_15: seven command codes decoded, seven echo reply
// RULE_16: eight-bit registers loaded by write commands
// RULE_17: command executes on chip select release
// RULE_18: unimplemented bits read zero, ignore writes
// RULE_19: non-fault status bits follow own conditions; the code holds them at the written value while the self-test write is unlocked
// RULE_20: commands accepted any time, no preamble
// RULE_21: several devices share bus in parallel only
// RULE_22: system status layout, error in bit three
// RULE_23: chip select changes only with clock low
// RULE_24: clock and data ignored while deselected
// RULE_25: error flag sticky until written zero
// RULE_26: read reply carries register byte low
package spi_regs_pkg;

  localparam int WORD_BITS   = 16;
  localparam int DATA_BITS   = 8;
  localparam int CMD_LSB     = 12;
  localparam int ADDR_LSB    = 8;
  localparam int CNT_BITS    = 5;
  localparam logic [4:0] FRAME_PULSES = 5'h10;

  typedef enum logic [3:0] {
    CMD_ECHO      = 4'h0,
    CMD_RD_CFG    = 4'h1,
    CMD_WR_CFG    = 4'h2,
    CMD_RD_STATUS = 4'h3,
    CMD_WR_STATUS = 4'h4,
    CMD_RD_CTRL   = 4'h5,
    CMD_WR_CTRL   = 4'h6,
    CMD_ECHO_RESP = 4'h7
  } cmd_t;

  localparam int CFG_COUNT  = 12;
  localparam int CTRL_COUNT = 12;

  localparam logic [3:0] SYS_STATUS_ADDR  = 4'hd;
  localparam logic [7:0] SYS_STATUS_RESET = 8'h00;
  localparam logic [7:0] SYS_STATUS_MASK  = 8'hff;
  localparam int ST_ANY_FAULT   = 7;
  localparam int ST_KEY_SWITCH  = 6;
  localparam int ST_POWER_EN    = 5;
  localparam int ST_BATTERY_SW  = 4;
  localparam int ST_SPI_ERROR   = 3;
  localparam int ST_SUPPLY_MSB  = 2;

  localparam logic [3:0] CTRL_UNLOCK_ADDR = 4'hb;
  localparam int         CTRL_UNLOCK_BIT  = 7;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] CTRL_MASK        = 8'hff;

  // register 11 in the top byte, register 0 in the bottom byte
  localparam logic [95:0] CFG_RESET_VALUES = {
    8'h53, 8'hca, 8'h80, 8'h80, 8'h10, 8'h00,
    8'h18, 8'h01, 8'h10, 8'h10, 8'h10, 8'h10};
  localparam logic [95:0] CFG_MASKS = {
    8'hff, 8'hff, 8'hd7, 8'hd7, 8'hd7, 8'h83,
    8'h9b, 8'hff, 8'hdf, 8'h9f, 8'h9f, 8'h9f};

  localparam int PIN_BITS = 10;
  localparam logic [9:0] PIN_RESET = 10'h200;

endpackage

// ### spi_regs_props.sv
/*
  Port checker for the serial register slave.
  Assumes it is bound onto spi_register_access_slave.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_regs_props (
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic        CHIP_SELECT_N,
  input wire logic        SCLK,
  input wire logic        SERIAL_OUT,
  input wire logic        SERIAL_OUT_OE,
  input wire logic        KEY_SWITCH_STATE,
  input wire logic [95:0] CFG_REGS,
  input wire logic [95:0] CTRL_REGS,
  input wire logic [7:0]  SYS_STATUS,
  input wire logic        SELF_TEST_WRITE_UNLOCK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence s_idle; CHIP_SELECT_N[*5]; endsequence
  sequence s_busy; (!CHIP_SELECT_N)[*5]; endsequence
  sequence s_locked; (!SELF_TEST_WRITE_UNLOCK)[*3]; endsequence
  property p_oe_off; s_idle |-> !SERIAL_OUT_OE; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_on; $fell(CHIP_SELECT_N) |-> ##[1:5] SERIAL_OUT_OE; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output not enabled after select");
  property p_so_low; !SERIAL_OUT_OE |-> !SERIAL_OUT; endproperty
  a_so_low: assert property (p_so_low)
    else $error("output data while disabled");
  property p_so_edge;
    SERIAL_OUT_OE && $past(SERIAL_OUT_OE) && $changed(SERIAL_OUT) |-> !$past(SCLK, 2);
  endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("output changed away from clock fall");
  property p_regs_hold; s_busy |-> $stable(CFG_REGS) && $stable(CTRL_REGS); endproperty
  a_regs_hold: assert property (p_regs_hold)
    else $error("register changed inside a frame");
  property p_key;
    (!SELF_TEST_WRITE_UNLOCK && $stable(KEY_SWITCH_STATE))[*6]
      |-> SYS_STATUS[spi_regs_pkg::ST_KEY_SWITCH] == KEY_SWITCH_STATE;
  endproperty
  a_key: assert property (p_key)
    else $error("key bit not following input");
  property p_any; s_locked ##0 (|SYS_STATUS[3:0]) |-> ##[0:2] SYS_STATUS[7]; endproperty
  a_any: assert property (p_any)
    else $error("summary fault bit missing");
  property p_sticky;
    SYS_STATUS[3] && !CHIP_SELECT_N && !SELF_TEST_WRITE_UNLOCK |=> SYS_STATUS[3];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag dropped without a write");
endmodule
bind spi_register_access_slave spi_regs_props i_props (.CLK_SYS, .NRST, .CHIP_SELECT_N,
  .SCLK, .SERIAL_OUT, .SERIAL_OUT_OE, .KEY_SWITCH_STATE, .CFG_REGS, .CTRL_REGS,
  .SYS_STATUS, .SELF_TEST_WRITE_UNLOCK);
`default_nettype wire

// ### test_spi_register_access_slave.sv
/*
  Self-checking bench for the serial register slave.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_spi_register_access_slave;
  logic        clk_sys, nrst, cs_n, sclk, si, so, so_oe, unlock;
  logic        so_pin;
  logic        key, pwr, bat, oth;
  logic [2:0]  sup;
  logic [7:0]  status;
  logic [95:0] cfg, ctrl, keep;
  logic [15:0] rep;
  int          fail_count, n_compared;
  logic [15:0] bad_w [5] = '{16'h2155, 16'h2155, 16'h8000, 16'h2c11, 16'h4000};
  int          bad_n [5] = '{15, 17, 16, 16, 16};

  spi_register_access_slave i_dut (.CLK_SYS(clk_sys), .NRST(nrst), .CHIP_SELECT_N(cs_n),
    .SCLK(sclk), .SERIAL_IN(si), .SERIAL_OUT(so), .SERIAL_OUT_OE(so_oe),
    .KEY_SWITCH_STATE(key), .POWER_ENABLE_STATE(pwr), .BATTERY_SWITCH_STATE(bat),
    .SENSOR_SUPPLY_FAULT(sup), .OTHER_FAULT(oth), .CFG_REGS(cfg), .CTRL_REGS(ctrl),
    .SYS_STATUS(status), .SELF_TEST_WRITE_UNLOCK(unlock));
  // floating line shown as the inverse of so, which is held low while disabled, so it reads as one
  assign so_pin = so_oe ? so : ~so;
  spi_host_model i_host (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so_pin));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tx(input logic [15:0] w, input int n = 16);
    i_host.xfer(w, n, rep);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_echo;
    chk("cfg reset", cfg, spi_regs_pkg::CFG_RESET_VALUES);
    chk("status reset", status, 8'h00);
    tx(16'h0abc);
    chk("first reply", rep, 16'h0000);
    chk("oe idle", so_oe, 1'b0);
    tx(16'h0f00);
    chk("echo", rep, 16'h7abc);
    tx(16'h0000);
    chk("echo top", rep, 16'h7f00);
  endtask
  task automatic t_cfg;
    tx(16'h23ff);
    chk("cfg3", cfg[31:24], 8'hff & spi_regs_pkg::CFG_MASKS[31:24]);
    tx(16'h1300);
    chk("write echo", rep, 16'h23ff);
    tx(16'h0000);
    chk("cfg read", rep, {8'h13, spi_regs_pkg::CFG_MASKS[31:24]});
  endtask
  task automatic t_ctrl;
    tx(16'h65a5);
    chk("ctrl5", ctrl[47:40], 8'ha5);
    tx(16'h5500);
    tx(16'h0000);
    chk("ctrl read", rep, 16'h55a5);
  endtask
  task automatic t_err;
    for (int k = 0; k < 5; k++) begin
      keep = cfg;
      tx(bad_w[k], bad_n[k]);
      chk("discard", cfg, keep);
      chk("error bit", status[3], 1'b1);
      tx(16'h4d00);
      chk("error reply", rep, 16'h3d08);
      chk("cleared", status[3], 1'b0);
    end
    tx(16'h4d08);
    chk("one ignored", status[3], 1'b0);
  endtask
  task automatic t_status;
    key = 1'b1;
    sup = 3'b001;
    wait_clk(10);
    chk("fault in", status, 8'hc1);
    sup = 3'b000;
    wait_clk(10);
    chk("fault sticky", status, 8'hc1);
    tx(16'h4d00);
    chk("fault clear", status, 8'h40);
    oth = 1'b1;
    wait_clk(10);
    chk("any fault", status, 8'hc0);
    oth = 1'b0;
    key = 1'b0;
    pwr = 1'b1;
    bat = 1'b1;
    wait_clk(10);
    chk("levels", status, 8'h30);
    tx(16'h3d00);
    tx(16'h0000);
    chk("status read", rep, 16'h3d30);
  endtask
  task automatic t_unlock;
    tx(16'h6b80);
    chk("unlock", unlock, 1'b1);
    tx(16'h4d5a);
    chk("free write", status, 8'h5a);
    sup = 3'b100;
    wait_clk(10);
    chk("no record", status, 8'h5a);
    sup = 3'b000;
    tx(16'h6b00);
    chk("relock", unlock, 1'b0);
    chk("resume", status, 8'hba);
    tx(16'h4d00);
    chk("final clear", status, 8'h30);
  endtask

  initial begin
    nrst = 1'b0;
    {key, pwr, bat, oth} = 4'h0;
    sup = 3'b000;
    fail_count = 0;
    n_compared = 0;
    wait_clk(10);
    nrst = 1'b1;
    wait_clk(4);
    t_echo;
    t_cfg;
    t_ctrl;
    t_err;
    t_status;
    t_unlock;
    end_of_test;
  end
endmodule
`default_nettype wire
